/* File: core/two_level_interrupt_controller.sv */
// The AXI4-Lite register port and the register offsets were left to the implementer.
module two_level_interrupt_controller #(
	parameter logic [31:0] SOURCE_MASK = intc_pkg::SOURCE_MASK
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic [31:0] SOURCE_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	output logic             NORMAL_REQUEST_O,
	output logic             FAST_REQUEST_O,
	output logic             EVENT_IRQ_O
);

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	function automatic logic [7:0] word_of(input logic [7:0] addr);
		word_of = {addr[7:2], 2'b00};
	endfunction : word_of

	// Registers
	logic [31:0] source_reg;
	logic [31:0] normal_en_reg;
	logic [31:0] normal_en_next;
	logic [31:0] fast_en_reg;
	logic [31:0] fast_en_next;
	logic [31:0] prog_reg;
	logic [31:0] prog_next;
	logic [intc_pkg::EV_W-1:0] ev_stat_reg;
	logic [intc_pkg::EV_W-1:0] ev_stat_next;
	logic [intc_pkg::EV_W-1:0] ev_mask_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        aw_rdy_reg;
	logic        w_rdy_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        ar_rdy_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        normal_req_reg;
	logic        fast_req_reg;
	logic        ev_irq_reg;

	// Raw, status and request formation
	wire         fast_or_w;
	wire [31:0]  normal_raw_w;
	wire [31:0]  fast_raw_w;
	wire [31:0]  normal_stat_w;
	wire [31:0]  fast_stat_w;
	wire [31:0]  fast_stat_low_w;

	assign fast_stat_low_w = {source_reg[31:2] & fast_en_reg[31:2],
		prog_reg[intc_pkg::PROG_FAST_BIT], 1'b0};
	assign fast_or_w     = |fast_stat_low_w[31:1];
	assign normal_raw_w  = {source_reg[31:2],
		prog_reg[intc_pkg::PROG_NORMAL_BIT], fast_or_w};
	assign fast_raw_w    = {source_reg[31:2],
		prog_reg[intc_pkg::PROG_FAST_BIT], fast_or_w};
	assign normal_stat_w = {normal_raw_w[31:2] & normal_en_reg[31:2],
		normal_raw_w[1:0]};
	assign fast_stat_w   = {fast_stat_low_w[31:1], fast_or_w};

	// Bus write decode
	wire         do_write_w;
	wire [7:0]   wa_w;
	wire [31:0]  wbits_w;
	wire         wr_nen_w;
	wire         wr_ncl_w;
	wire         wr_fen_w;
	wire         wr_fcl_w;
	wire         wr_prog_w;
	wire         wr_evs_w;
	wire         wr_evm_w;
	wire         wr_hit_w;

	assign do_write_w = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
	assign wa_w       = word_of(aw_addr_reg);
	assign wbits_w    = w_data_reg & lane_mask(w_strb_reg);
	assign wr_nen_w   = do_write_w && wa_w == intc_pkg::OFF_NORMAL_ENABLE;
	assign wr_ncl_w   = do_write_w && wa_w == intc_pkg::OFF_NORMAL_CLEAR;
	assign wr_fen_w   = do_write_w && wa_w == intc_pkg::OFF_FAST_ENABLE;
	assign wr_fcl_w   = do_write_w && wa_w == intc_pkg::OFF_FAST_CLEAR;
	assign wr_prog_w  = do_write_w && wa_w == intc_pkg::OFF_PROG_CONFIG;
	assign wr_evs_w   = do_write_w && wa_w == intc_pkg::OFF_EVENT_STATUS;
	assign wr_evm_w   = do_write_w && wa_w == intc_pkg::OFF_EVENT_MASK;
	assign wr_hit_w   = wr_nen_w || wr_ncl_w || wr_fen_w || wr_fcl_w || wr_prog_w
		|| wr_evs_w || wr_evm_w
		|| wa_w == intc_pkg::OFF_NORMAL_RAW || wa_w == intc_pkg::OFF_NORMAL_STATUS
		|| wa_w == intc_pkg::OFF_FAST_RAW || wa_w == intc_pkg::OFF_FAST_STATUS;

	// Only source bits are writable: bit 0, bit 1 and reserved bits stay zero
	wire [31:0]  en_bits_w;
	assign en_bits_w = wbits_w & SOURCE_MASK;

	// Setting at one level clears the other; clears touch only their own bits
	assign normal_en_next = wr_nen_w ? (normal_en_reg | en_bits_w) :
		wr_ncl_w ? (normal_en_reg & ~en_bits_w) :
		wr_fen_w ? (normal_en_reg & ~en_bits_w) :
		normal_en_reg;
	assign fast_en_next = wr_fen_w ? (fast_en_reg | en_bits_w) :
		wr_fcl_w ? (fast_en_reg & ~en_bits_w) :
		wr_nen_w ? (fast_en_reg & ~en_bits_w) :
		fast_en_reg;
	assign prog_next = wr_prog_w ?
		((prog_reg & ~lane_mask(w_strb_reg)) | wbits_w) & intc_pkg::PROG_MASK :
		prog_reg;

	// Event flags: set wins over a write-one clear
	wire [intc_pkg::EV_W-1:0] ev_set_w;
	wire [intc_pkg::EV_W-1:0] ev_clr_w;
	assign ev_set_w[intc_pkg::EV_NORMAL_RISE] = (|normal_stat_w) && !normal_req_reg;
	assign ev_set_w[intc_pkg::EV_FAST_RISE]   = fast_or_w && !fast_req_reg;
	assign ev_set_w[intc_pkg::EV_BUS_ERROR]   = do_write_w && !wr_hit_w;
	assign ev_clr_w     = wr_evs_w ? wbits_w[intc_pkg::EV_W-1:0] : '0;
	assign ev_stat_next = ev_set_w | (ev_stat_reg & ~ev_clr_w);

	// Read decode
	wire [7:0]   ra_w;
	wire         rd_hit_w;
	wire [31:0]  rd_data_w;
	assign ra_w = word_of(ARADDR_I);
	assign rd_hit_w = ra_w <= intc_pkg::OFF_EVENT_MASK;
	assign rd_data_w =
		ra_w == intc_pkg::OFF_NORMAL_RAW    ? normal_raw_w :
		ra_w == intc_pkg::OFF_NORMAL_ENABLE ? normal_en_reg :
		ra_w == intc_pkg::OFF_NORMAL_STATUS ? normal_stat_w :
		ra_w == intc_pkg::OFF_FAST_RAW      ? fast_raw_w :
		ra_w == intc_pkg::OFF_FAST_ENABLE   ? fast_en_reg :
		ra_w == intc_pkg::OFF_FAST_STATUS   ? fast_stat_w :
		ra_w == intc_pkg::OFF_PROG_CONFIG   ? prog_reg :
		ra_w == intc_pkg::OFF_EVENT_STATUS  ? {29'h0, ev_stat_reg} :
		ra_w == intc_pkg::OFF_EVENT_MASK    ? {29'h0, ev_mask_reg} :
		32'h0;

	// Source sampling and control state
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			source_reg    <= 32'h0;
			normal_en_reg <= intc_pkg::ENABLE_RESET;
			fast_en_reg   <= intc_pkg::ENABLE_RESET;
			prog_reg      <= intc_pkg::PROG_RESET;
			ev_stat_reg   <= intc_pkg::EVENT_RESET;
			ev_mask_reg   <= intc_pkg::EVENT_RESET;
		end else begin
			source_reg    <= SOURCE_I & SOURCE_MASK;
			normal_en_reg <= normal_en_next;
			fast_en_reg   <= fast_en_next;
			prog_reg      <= prog_next;
			ev_stat_reg   <= ev_stat_next;
			if (wr_evm_w) begin
				ev_mask_reg <= wbits_w[intc_pkg::EV_W-1:0];
			end
		end
	end

	// Request outputs
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			normal_req_reg <= 1'b0;
			fast_req_reg   <= 1'b0;
			ev_irq_reg     <= 1'b0;
		end else begin
			normal_req_reg <= |normal_stat_w;
			fast_req_reg   <= fast_or_w;
			ev_irq_reg     <= |(ev_stat_next & ev_mask_reg);
		end
	end

	// Write channels
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			aw_rdy_reg  <= 1'b1;
			w_rdy_reg   <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= intc_pkg::RESP_OKAY;
			aw_addr_reg <= 8'h0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
		end else begin
			if (aw_rdy_reg && AWVALID_I) begin
				aw_rdy_reg  <= 1'b0;
				aw_addr_reg <= AWADDR_I;
			end
			if (w_rdy_reg && WVALID_I) begin
				w_rdy_reg  <= 1'b0;
				w_data_reg <= WDATA_I;
				w_strb_reg <= WSTRB_I;
			end
			if (do_write_w) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit_w ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
			end
			if (bvalid_reg && BREADY_I) begin
				bvalid_reg <= 1'b0;
				aw_rdy_reg <= 1'b1;
				w_rdy_reg  <= 1'b1;
			end
		end
	end

	// Read channels
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ar_rdy_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= intc_pkg::RESP_OKAY;
		end else if (ar_rdy_reg && ARVALID_I) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_data_w;
			rresp_reg  <= rd_hit_w ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
		end else if (rvalid_reg && RREADY_I) begin
			ar_rdy_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	assign AWREADY_O        = aw_rdy_reg;
	assign WREADY_O         = w_rdy_reg;
	assign BVALID_O         = bvalid_reg;
	assign BRESP_O          = bresp_reg;
	assign ARREADY_O        = ar_rdy_reg;
	assign RVALID_O         = rvalid_reg;
	assign RDATA_O          = rdata_reg;
	assign RRESP_O          = rresp_reg;
	assign NORMAL_REQUEST_O = normal_req_reg;
	assign FAST_REQUEST_O   = fast_req_reg;
	assign EVENT_IRQ_O      = ev_irq_reg;

	// Checks
	a_level_exclusive: assert property (
		@(posedge CLK_I) disable iff (RST_I) (normal_en_reg & fast_en_reg) == 32'h0)
		else $error("source enabled at both levels");

	a_reserved_inert: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		((normal_en_reg | fast_en_reg) & ~SOURCE_MASK) == 32'h0)
		else $error("non-source enable bit set");

	a_clear_only_own: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wr_ncl_w |=> normal_en_reg == ($past(normal_en_reg) & ~$past(en_bits_w))
		&& fast_en_reg == $past(fast_en_reg))
		else $error("normal clear wrong");

	a_fast_steals: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wr_fen_w |=> (fast_en_reg & $past(en_bits_w)) == $past(en_bits_w)
		&& (normal_en_reg & $past(en_bits_w)) == 32'h0)
		else $error("fast enable did not take over");

	a_reset_quiet: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		$past(RST_I) |-> normal_en_reg == 32'h0 && fast_en_reg == 32'h0
		&& prog_reg == 32'h0 && !NORMAL_REQUEST_O && !FAST_REQUEST_O)
		else $error("state not cleared by reset");

	a_prog_unmasked: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		prog_reg[intc_pkg::PROG_NORMAL_BIT] |-> (normal_raw_w[intc_pkg::BIT_PROG]
		&& normal_stat_w[intc_pkg::BIT_PROG]) ##1 NORMAL_REQUEST_O)
		else $error("programmed normal interrupt lost");

	a_fast_or_path: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(fast_en_reg & source_reg) != 32'h0 || prog_reg[intc_pkg::PROG_FAST_BIT]
		|=> FAST_REQUEST_O && NORMAL_REQUEST_O)
		else $error("fast request or bit 0 missing");

	a_masked_silent: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		normal_en_reg == 32'h0 && fast_en_reg == 32'h0 && prog_reg == 32'h0
		|=> !NORMAL_REQUEST_O && !FAST_REQUEST_O)
		else $error("request without enabled source");

	a_status_follows: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		$stable(SOURCE_I) && $stable(normal_en_reg) |=>
		normal_stat_w[31:2] == ($past(SOURCE_I[31:2]) & SOURCE_MASK[31:2] & normal_en_reg[31:2]))
		else $error("status not raw and enable");

	a_raw_follows: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		!$past(RST_I) |-> normal_raw_w[31:2] == ($past(SOURCE_I[31:2]) & SOURCE_MASK[31:2]))
		else $error("raw bits do not follow sources");

	a_fast_raw_alike: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		fast_raw_w[31:2] == normal_raw_w[31:2]
		&& fast_raw_w[intc_pkg::BIT_FAST_OR] == |fast_stat_w[31:1]
		&& normal_raw_w[intc_pkg::BIT_FAST_OR] == |fast_stat_w[31:1])
		else $error("level raw registers disagree");

	a_fast_status_and: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		fast_stat_w[31:2] == (fast_raw_w[31:2] & fast_en_reg[31:2]))
		else $error("fast status not raw and enable");

	a_normal_req_or: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		!$past(RST_I) |-> NORMAL_REQUEST_O == $past(|normal_stat_w))
		else $error("normal request not OR of status");

	a_fast_req_or: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		!$past(RST_I) |-> FAST_REQUEST_O == $past(|fast_stat_w[31:1]))
		else $error("fast request not OR of status");

	a_prog_fast_path: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		fast_raw_w[intc_pkg::BIT_PROG] == prog_reg[intc_pkg::PROG_FAST_BIT]
		&& fast_stat_w[intc_pkg::BIT_PROG] == prog_reg[intc_pkg::PROG_FAST_BIT])
		else $error("programmed fast bit not in raw and status");

	a_normal_set_adds: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wr_nen_w |=> normal_en_reg == ($past(normal_en_reg) | $past(en_bits_w))
		&& (fast_en_reg & $past(en_bits_w)) == 32'h0)
		else $error("normal enable write wrong");

	a_fast_clear_own: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		wr_fcl_w |=> fast_en_reg == ($past(fast_en_reg) & ~$past(en_bits_w))
		&& normal_en_reg == $past(normal_en_reg))
		else $error("fast clear wrong");

	a_prog_reserved: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		(prog_reg & ~intc_pkg::PROG_MASK) == 32'h0)
		else $error("reserved programmed bit set");

	a_event_set_wins: assert property (
		@(posedge CLK_I) disable iff (RST_I)
		ev_set_w[intc_pkg::EV_BUS_ERROR] |=> ev_stat_reg[intc_pkg::EV_BUS_ERROR])
		else $error("bus error event lost");

endmodule : two_level_interrupt_controller

/* File: include/intc_pkg.sv */
package intc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFF_NORMAL_RAW    = 8'h00;
	localparam logic [7:0] OFF_NORMAL_ENABLE = 8'h04;
	localparam logic [7:0] OFF_NORMAL_CLEAR  = 8'h08;
	localparam logic [7:0] OFF_NORMAL_STATUS = 8'h0c;
	localparam logic [7:0] OFF_FAST_RAW      = 8'h10;
	localparam logic [7:0] OFF_FAST_ENABLE   = 8'h14;
	localparam logic [7:0] OFF_FAST_CLEAR    = 8'h18;
	localparam logic [7:0] OFF_FAST_STATUS   = 8'h1c;
	localparam logic [7:0] OFF_PROG_CONFIG   = 8'h20;
	localparam logic [7:0] OFF_EVENT_STATUS  = 8'h24;
	localparam logic [7:0] OFF_EVENT_MASK    = 8'h28;
	// Bit layout shared by every level register
	localparam int BIT_FAST_OR  = 0;
	localparam int BIT_PROG     = 1;
	localparam logic [31:0] SOURCE_MASK = 32'h000f_7fbc;
	// Programmed interrupt config fields
	localparam int PROG_NORMAL_BIT = 1;
	localparam int PROG_FAST_BIT   = 2;
	localparam logic [31:0] PROG_MASK = 32'h0000_0006;
	// Event status fields
	localparam int EV_NORMAL_RISE = 0;
	localparam int EV_FAST_RISE   = 1;
	localparam int EV_BUS_ERROR   = 2;
	localparam int EV_W           = 3;
	// Reset values
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] PROG_RESET   = 32'h0000_0000;
	localparam logic [2:0]  EVENT_RESET  = 3'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : intc_pkg

/* File: verif/core_model.sv */
module core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       normal_request_i,
	input  wire logic       fast_request_i,
	output logic      [7:0] normal_entries_o,
	output logic      [7:0] fast_entries_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic normal_seen_reg;
	logic fast_seen_reg;
	// Handler entry on each request rise, counted per level in normal_entries_o and fast_entries_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			normal_seen_reg  <= 1'b0;
			fast_seen_reg    <= 1'b0;
			normal_entries_o <= 8'h00;
			fast_entries_o   <= 8'h00;
		end else begin
			normal_seen_reg <= normal_request_i;
			fast_seen_reg   <= fast_request_i;
			if (normal_request_i && !normal_seen_reg) normal_entries_o <= normal_entries_o + 8'h01;
			if (fast_request_i && !fast_seen_reg) fast_entries_o <= fast_entries_o + 8'h01;
		end
	end
endmodule : core_model

/* File: verif/two_level_interrupt_controller_tb_top.sv */
module two_level_interrupt_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv, nreq, freq, evirq;
	logic [31:0] src, wdat, rdat;
	logic [7:0] awa, ara, n_ent, f_ent;
	logic [3:0] strb;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] d;
	int n_fail, n_checks;
	two_level_interrupt_controller u_two_level_interrupt_controller (.CLK_I(clk), .RST_I(rst), .SOURCE_I(src),
		.AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wdat), .WSTRB_I(strb), .WVALID_I(wv),
		.WREADY_O(wr), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(brdy), .ARADDR_I(ara), .ARVALID_I(arv),
		.ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rrdy),
		.NORMAL_REQUEST_O(nreq), .FAST_REQUEST_O(freq), .EVENT_IRQ_O(evirq));
	core_model u_core_model (.clk_i(clk), .rst_i(rst), .normal_request_i(nreq), .fast_request_i(freq),
		.normal_entries_o(n_ent), .fast_entries_o(f_ent));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	task automatic wr_strb(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awa <= a;
		wdat <= v;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		r = bresp;
		brdy <= 1'b0;
	endtask : wr_strb
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		wr_strb(a, v, 4'hf, r);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		v = rdat;
		r = rresp;
		rrdy <= 1'b0;
	endtask : rd_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a, d, rs);
		chk_word(d, exp);
	endtask : rd_chk
	task automatic drive_src(input logic [31:0] v);
		@(posedge clk);
		src <= v; // Held well past the capture latency
		repeat (3) @(posedge clk);
	endtask : drive_src
	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle
	task automatic test_reset_and_raw();
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_PROG_CONFIG, 32'h0000_0000);
		drive_src(32'hffff_fffc);
		rd_chk(intc_pkg::OFF_NORMAL_RAW, intc_pkg::SOURCE_MASK);
		rd_chk(intc_pkg::OFF_FAST_RAW, intc_pkg::SOURCE_MASK);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0000);
		chk_bit(nreq, 1'b0);
		wr_reg(intc_pkg::OFF_NORMAL_RAW, 32'h0000_0000, rs);
		chk_resp(rs, intc_pkg::RESP_OKAY);
		rd_chk(intc_pkg::OFF_NORMAL_RAW, intc_pkg::SOURCE_MASK);
		drive_src(32'h0000_0000);
	endtask : test_reset_and_raw
	task automatic test_normal_level();
		drive_src(32'h0000_0004);
		wr_reg(intc_pkg::OFF_NORMAL_ENABLE, 32'hffff_ffff, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, intc_pkg::SOURCE_MASK);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0004);
		settle();
		chk_bit(nreq, 1'b1);
		chk_bit(n_ent == 8'h01, 1'b1);
		wr_reg(intc_pkg::OFF_NORMAL_CLEAR, 32'h0000_0004, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, intc_pkg::SOURCE_MASK & 32'hffff_fffb);
		rd_chk(intc_pkg::OFF_NORMAL_CLEAR, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0000);
		settle();
		chk_bit(nreq, 1'b0);
		wr_reg(intc_pkg::OFF_NORMAL_CLEAR, 32'hffff_ffff, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0000);
	endtask : test_normal_level
	task automatic test_exclusive_levels();
		drive_src(32'h0000_0008);
		wr_reg(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0008, rs);
		wr_reg(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0008, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0008);
		rd_chk(intc_pkg::OFF_FAST_STATUS, 32'h0000_0009);
		rd_chk(intc_pkg::OFF_NORMAL_RAW, 32'h0000_0009);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0001);
		settle();
		chk_bit(freq, 1'b1);
		chk_bit(nreq, 1'b1);
		wr_reg(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0008, rs);
		rd_chk(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0008);
		wr_reg(intc_pkg::OFF_NORMAL_CLEAR, 32'h0000_0008, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0000);
		settle();
		chk_bit(freq, 1'b0);
		chk_bit(f_ent != 8'h00, 1'b1);
		drive_src(32'h0000_0000);
	endtask : test_exclusive_levels
	task automatic test_programmed();
		wr_reg(intc_pkg::OFF_PROG_CONFIG, 32'h0000_0002, rs);
		rd_chk(intc_pkg::OFF_NORMAL_RAW, 32'h0000_0002);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0002);
		settle();
		chk_bit(nreq, 1'b1);
		chk_bit(freq, 1'b0);
		wr_reg(intc_pkg::OFF_PROG_CONFIG, 32'h0000_0006, rs);
		rd_chk(intc_pkg::OFF_PROG_CONFIG, 32'h0000_0006);
		rd_chk(intc_pkg::OFF_FAST_RAW, 32'h0000_0003);
		rd_chk(intc_pkg::OFF_FAST_STATUS, 32'h0000_0003);
		settle();
		chk_bit(freq, 1'b1);
		wr_reg(intc_pkg::OFF_PROG_CONFIG, 32'h0000_0000, rs);
		rd_chk(intc_pkg::OFF_NORMAL_STATUS, 32'h0000_0000);
		settle();
		chk_bit(freq, 1'b0);
		chk_bit(nreq, 1'b0);
	endtask : test_programmed
	task automatic test_byte_lanes();
		wr_strb(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_ff04, 4'h1, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0004);
		wr_strb(intc_pkg::OFF_NORMAL_CLEAR, 32'hffff_ffff, 4'h2, rs);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0004);
		wr_reg(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0030, rs);
		wr_reg(intc_pkg::OFF_FAST_CLEAR, 32'h0000_0010, rs);
		rd_chk(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0020);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0004);
		wr_reg(intc_pkg::OFF_FAST_CLEAR, 32'hffff_ffff, rs);
		wr_reg(intc_pkg::OFF_NORMAL_CLEAR, 32'hffff_ffff, rs);
		rd_chk(intc_pkg::OFF_FAST_ENABLE, 32'h0000_0000);
		rd_chk(intc_pkg::OFF_NORMAL_ENABLE, 32'h0000_0000);
	endtask : test_byte_lanes
	task automatic test_bus_errors();
		rd_reg(8'h40, d, rs);
		chk_resp(rs, intc_pkg::RESP_SLVERR);
		chk_word(d, 32'h0000_0000);
		wr_reg(8'h40, 32'hffff_ffff, rs);
		chk_resp(rs, intc_pkg::RESP_SLVERR);
		wr_reg(intc_pkg::OFF_EVENT_MASK, 32'h0000_0004, rs);
		settle();
		chk_bit(evirq, 1'b1);
		wr_reg(intc_pkg::OFF_EVENT_STATUS, 32'h0000_0004, rs);
		settle();
		chk_bit(evirq, 1'b0);
	endtask : test_bus_errors
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst = 1'b1;
		{awv, wv, brdy, arv, rrdy} = 5'h00;
		{src, wdat, awa, ara, strb} = 84'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		test_reset_and_raw();
		test_normal_level();
		test_exclusive_levels();
		test_programmed();
		test_byte_lanes();
		test_bus_errors();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end
endmodule : two_level_interrupt_controller_tb_top
